// file: inc/fe_prog_consts.svh
`ifndef FE_PROG_CONSTS_SVH
`define FE_PROG_CONSTS_SVH

// ==========================================================
// Programming word layout.
`define WORD_BITS 47
`define CH_COUNT 8
`define CH_FIELD_BITS 5
`define PHASE_BITS 4
`define IMP_LSB 40
`define IMP_MSB 41
`define IMP_OPEN_BIT 42
`define GAIN_BIT 43
`define FC_LSB 44
`define FC_MSB 45
`define SPARE_BIT 46

// ==========================================================
// Divider and reset values.
`define DIV_STEPS 16
`define PHASE_ZERO 4'h0
`define WORD_RESET 47'h0000_0000_0000

`endif

// file: inc/fe_prog_pkg.sv
package fe_prog_pkg;

    // Input impedance choice after decoding gain and impedance bits.
    typedef enum logic [2:0] {
        IMP_50 = 3'h0,
        IMP_100 = 3'h1,
        IMP_200 = 3'h2,
        IMP_400 = 3'h3,
        IMP_1000 = 3'h4,
        IMP_2000 = 3'h5,
        IMP_OPEN = 3'h6
    } impedance_t;

    // Anti-alias filter corner.
    typedef enum logic [1:0] {
        FC_9MHZ = 2'h0,
        FC_10MHZ = 2'h1,
        FC_15MHZ = 2'h2,
        FC_18MHZ = 2'h3
    } corner_t;

endpackage : fe_prog_pkg

// file: design/frontend_program_word.sv
`timescale 1ns/1ps
`default_nettype none
`include "fe_prog_consts.svh"

// How it works
// - Nothing is valid until the first chip-select rising edge copies the 47-bit shift register into the live word.
// - Bits 0-39 channels, 40-42 impedance, 43 gain, 44-45 corner, 46 ignored.
// - High gain: codes select 50/100/200/1000 ohm; bit 42 opens feedback.
// - Low gain: codes select 100/200/400/2000 ohm.
// - Gain bit 0 gives low gain, 1 gives high gain.
// - Corner bits select 9, 10, 15 or 18 MHz independently.
// - Each channel mixer has sixteen phases from a four-bit field.
// - Lowest bit of each channel field shuts that mixer off when 1.
// - Power-down line turns all channels off regardless of shutdown bits.
// - Chip-select rising edge moves channel fields into the phase dividers.
// - Load presets divider counters; phasing acts from next mixer clock.
// - Phase weights: bit+4 22.5, bit+3 45, bit+2 90, bit+1 180 degrees.
// - Serial output forwards shifted data for daisy chaining.
// - All channel phases come from dividing one shared mixer clock.
// - Data is sampled on each rising serial clock edge while chip-select is low.
// - Standby-select high enables VGA path; low enables the mixers.
module frontend_program_word #(
    parameter int CHANNELS = `CH_COUNT
) (
    // System.
    input wire logic clk,
    input wire logic srst,
    // Serial programming pins.
    input wire logic ser_clk,
    input wire logic ser_data_in,
    input wire logic chip_select_n,
    output logic ser_data_out,
    // Mixer reference and mode pins.
    input wire logic mixer_reference_clock,
    input wire logic power_down_line,
    input wire logic standby_select,
    // Decoded configuration.
    output logic configured,
    output fe_prog_pkg::impedance_t input_impedance_select,
    output logic lna_gain_select,
    output fe_prog_pkg::corner_t filter_corner_select,
    output logic vga_enable,
    // Per-channel mixer state.
    output logic [CHANNELS-1:0] mixer_enable,
    output logic [CHANNELS*`PHASE_BITS-1:0] lo_phase
);

    // ==========================================================
    // Pin synchronisers.
    logic [2:0] sck_sync_r;
    logic [2:0] mck_sync_r;
    logic [2:0] cs_sync_r;
    logic [1:0] din_sync_r;
    logic [1:0] pd_sync_r;
    logic [1:0] sb_sync_r;

    // Chip-select idles high, so its stages reset high and reset makes no false load edge.
    always_ff @(posedge clk) begin
        if (srst) begin
            sck_sync_r <= 3'h0;
            mck_sync_r <= 3'h0;
            cs_sync_r <= 3'h7;
            din_sync_r <= 2'h0;
            pd_sync_r <= 2'h0;
            sb_sync_r <= 2'h0;
        end else begin
            sck_sync_r <= {sck_sync_r[1:0], ser_clk};
            mck_sync_r <= {mck_sync_r[1:0], mixer_reference_clock};
            cs_sync_r <= {cs_sync_r[1:0], chip_select_n};
            din_sync_r <= {din_sync_r[0], ser_data_in};
            pd_sync_r <= {pd_sync_r[0], power_down_line};
            sb_sync_r <= {sb_sync_r[0], standby_select};
        end
    end

    // Edges use the second and third stages only.
    wire sck_rise = sck_sync_r[1] & ~sck_sync_r[2];
    wire mck_rise = mck_sync_r[1] & ~mck_sync_r[2];
    wire cs_rise = cs_sync_r[1] & ~cs_sync_r[2];
    wire cs_low = ~cs_sync_r[1];
    wire din_s = din_sync_r[1];
    wire pd_s = pd_sync_r[1];
    wire sb_s = sb_sync_r[1];

    // ==========================================================
    // Shift register and active word.
    logic [`WORD_BITS-1:0] shift_r;
    logic [`WORD_BITS-1:0] shift_nxt;
    logic [`WORD_BITS-1:0] active_r;
    logic loaded_r;
    logic dout_r;

    // LSB enters first and travels toward bit 0, so the last bit lands at the top.
    assign shift_nxt = {din_s, shift_r[`WORD_BITS-1:1]};
    wire shift_en = sck_rise & cs_low;

    // The chained output is the bit leaving the bottom, 47 shifts behind the input.
    always_ff @(posedge clk) begin
        if (srst) begin
            shift_r <= `WORD_RESET;
            dout_r <= 1'b0;
        end else if (shift_en) begin
            shift_r <= shift_nxt;
            dout_r <= shift_r[0];
        end
    end

    // The live word moves only on the load edge, never while bits shift in.
    always_ff @(posedge clk) begin
        if (srst) begin
            active_r <= `WORD_RESET;
            loaded_r <= 1'b0;
        end else if (cs_rise) begin
            active_r <= shift_r;
            loaded_r <= 1'b1;
        end
    end

    // ==========================================================
    // Shared analog configuration decode.
    wire [1:0] imp_code = active_r[`IMP_MSB:`IMP_LSB];
    wire imp_open = active_r[`IMP_OPEN_BIT];
    wire gain_hi = active_r[`GAIN_BIT];
    wire [1:0] fc_code = active_r[`FC_MSB:`FC_LSB];
    fe_prog_pkg::impedance_t imp_dec;

    // Bit 42 opens the feedback only at high gain; at low gain it is ignored.
    // The spare bit at the top of the word is never decoded.
    always_comb begin
        if (gain_hi && imp_open) begin
            imp_dec = fe_prog_pkg::IMP_OPEN;
        end else if (gain_hi) begin
            unique case (imp_code)
                2'h0: imp_dec = fe_prog_pkg::IMP_50;
                2'h1: imp_dec = fe_prog_pkg::IMP_100;
                2'h2: imp_dec = fe_prog_pkg::IMP_200;
                2'h3: imp_dec = fe_prog_pkg::IMP_1000;
            endcase
        end else begin
            unique case (imp_code)
                2'h0: imp_dec = fe_prog_pkg::IMP_100;
                2'h1: imp_dec = fe_prog_pkg::IMP_200;
                2'h2: imp_dec = fe_prog_pkg::IMP_400;
                2'h3: imp_dec = fe_prog_pkg::IMP_2000;
            endcase
        end
    end

    // ==========================================================
    // Mode gates shared by the imaging path and the mixers.
    // Power-down beats both modes; standby-select picks one of the two.
    wire mode_live = loaded_r & ~pd_s;
    wire vga_gate = mode_live & sb_s;
    wire mix_gate = mode_live & ~sb_s;

    // ==========================================================
    // Registered outputs.
    always_ff @(posedge clk) begin
        if (srst) begin
            configured <= 1'b0;
            input_impedance_select <= fe_prog_pkg::IMP_100;
            lna_gain_select <= 1'b0;
            filter_corner_select <= fe_prog_pkg::FC_9MHZ;
            vga_enable <= 1'b0;
            ser_data_out <= 1'b0;
        end else begin
            configured <= loaded_r;
            input_impedance_select <= imp_dec;
            lna_gain_select <= gain_hi;
            filter_corner_select <= fe_prog_pkg::corner_t'(fc_code);
            vga_enable <= vga_gate;
            ser_data_out <= dout_r;
        end
    end

    // ==========================================================
    // Per-channel phase dividers on the shared mixer clock.
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
            localparam int BASE = ch * `CH_FIELD_BITS;
            logic [`PHASE_BITS-1:0] phase_r;
            logic [`PHASE_BITS-1:0] field_phase;
            logic off_bit;
            logic mix_nxt;

            // Field bit+4 weighs 22.5 degrees, so the field is bit-reversed.
            assign field_phase = {shift_r[BASE+1], shift_r[BASE+2],
                                  shift_r[BASE+3], shift_r[BASE+4]};
            assign off_bit = active_r[BASE];
            assign mix_nxt = mix_gate & ~off_bit;

            // A load and a mixer edge in one cycle cannot both act: the load wins,
            // so the preset is exact; the controller keeps the clock still to avoid it.
            always_ff @(posedge clk) begin
                if (srst) begin
                    phase_r <= `PHASE_ZERO;
                end else if (cs_rise) begin
                    phase_r <= field_phase;
                end else if (mck_rise) begin
                    phase_r <= phase_r + 4'h1;
                end
            end

            always_ff @(posedge clk) begin
                if (srst) begin
                    mixer_enable[ch] <= 1'b0;
                    lo_phase[ch*`PHASE_BITS +: `PHASE_BITS] <= `PHASE_ZERO;
                end else begin
                    mixer_enable[ch] <= mix_nxt;
                    lo_phase[ch*`PHASE_BITS +: `PHASE_BITS] <= phase_r;
                end
            end
        end
    endgenerate

endmodule : frontend_program_word
`default_nettype wire

// file: testbench/fe_prog_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// Port relations of the program word block.
module fe_prog_monitor #(
    parameter int CHANNELS = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ser_clk,
    input wire logic chip_select_n,
    input wire logic ser_data_out,
    input wire logic mixer_reference_clock,
    input wire logic power_down_line,
    input wire logic standby_select,
    input wire logic configured,
    input wire fe_prog_pkg::impedance_t input_impedance_select,
    input wire logic lna_gain_select,
    input wire fe_prog_pkg::corner_t filter_corner_select,
    input wire logic vga_enable,
    input wire logic [CHANNELS-1:0] mixer_enable,
    input wire logic [CHANNELS*4-1:0] lo_phase
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    chk_mode_excl: assert property (vga_enable |-> mixer_enable == '0)
        else $error("vga and mixers on together");
    chk_unconf_off: assert property (!configured |-> mixer_enable == '0 && !vga_enable)
        else $error("output on before first load");
    chk_pd_kills: assert property (power_down_line [*4] |=> mixer_enable == '0 && !vga_enable)
        else $error("power down ignored");
    chk_shift_hold: assert property (!chip_select_n [*8] |-> $stable({configured, lna_gain_select,
        filter_corner_select, input_impedance_select}))
        else $error("settings moved while shifting");
    chk_hi_gain_imp: assert property (lna_gain_select |-> !(input_impedance_select inside
        {fe_prog_pkg::IMP_400, fe_prog_pkg::IMP_2000}))
        else $error("low gain impedance in high gain");
    chk_lo_gain_imp: assert property (!lna_gain_select |-> !(input_impedance_select inside
        {fe_prog_pkg::IMP_50, fe_prog_pkg::IMP_1000, fe_prog_pkg::IMP_OPEN}))
        else $error("high gain impedance in low gain");
    chk_phase_hold: assert property ((!mixer_reference_clock && chip_select_n) [*8] |->
        $stable(lo_phase))
        else $error("phase moved without mixer clock");
    chk_chain_hold: assert property (!ser_clk [*8] |-> $stable(ser_data_out))
        else $error("chain output moved without shift");
    chk_vga_on: assert property ((configured && standby_select && !power_down_line) [*6] |->
        vga_enable)
        else $error("vga path not enabled");
endmodule : fe_prog_monitor
`default_nettype wire

// file: testbench/fe_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// Controller on the serial port and mixer clock.
module fe_host_model (
    input wire logic clk,
    input wire logic ser_data_out,
    output var logic ser_clk,
    output var logic ser_data_in,
    output var logic chip_select_n,
    output var logic mixer_reference_clock
);
    initial begin
        ser_clk = 0;
        ser_data_in = 0;
        chip_select_n = 1;
        mixer_reference_clock = 0;
    end
    // The mixer clock is idle here, so the load never races a divider step.
    task automatic send(input logic [46:0] v, input int hp, output logic [46:0] seen);
        @(posedge clk) #1 chip_select_n = 0;
        for (int i = 0; i < 47; i++) begin
            ser_data_in = v[i];
            repeat (hp) @(posedge clk);
            #1 if (i > 0) seen[i-1] = ser_data_out;
            ser_clk = 1;
            repeat (hp) @(posedge clk);
            #1 ser_clk = 0;
        end
        repeat (hp) @(posedge clk);
        #1 seen[46] = ser_data_out;
        chip_select_n = 1;
        ser_data_in = ~ser_data_in;
    endtask : send
    // Whole mixer clock cycles only, each starting with its high phase.
    task automatic run(input int n);
        repeat (n) begin
            @(posedge clk) #1 mixer_reference_clock = 1;
            repeat (3) @(posedge clk);
            #1 mixer_reference_clock = 0;
            repeat (2) @(posedge clk);
        end
    endtask : run
endmodule : fe_host_model
`default_nettype wire

// file: testbench/beamformer_program_shift_word_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
// ======
// Random and corner program words through the host model.
module beamformer_program_shift_word_tb;
    logic clk = 0, srst = 1, pd = 0, sby = 0;
    wire logic sck, sdi, csn, mrc, sdo, cfg, gain, vga;
    wire fe_prog_pkg::impedance_t imp;
    wire fe_prog_pkg::corner_t fc;
    wire logic [7:0] men;
    wire logic [31:0] lop;
    int bad_count = 0, total_checks = 0, cyc = 0;
    logic [46:0] w, prev, got;
    logic [3:0] ph;
    always #2 clk = ~clk;
    fe_host_model H (.clk(clk), .ser_data_out(sdo), .ser_clk(sck), .ser_data_in(sdi),
        .chip_select_n(csn), .mixer_reference_clock(mrc));
    frontend_program_word DUT (.clk(clk), .srst(srst), .ser_clk(sck), .ser_data_in(sdi),
        .chip_select_n(csn), .ser_data_out(sdo), .mixer_reference_clock(mrc),
        .power_down_line(pd), .standby_select(sby), .configured(cfg),
        .input_impedance_select(imp), .lna_gain_select(gain), .filter_corner_select(fc),
        .vga_enable(vga), .mixer_enable(men), .lo_phase(lop));
    task conclude;
        if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            conclude();
        end
    end
    function automatic fe_prog_pkg::impedance_t imp_of(input logic [46:0] v);
        logic [23:0] lut = 24'h888AD1;
        if (v[43] && v[42]) return fe_prog_pkg::IMP_OPEN;
        return fe_prog_pkg::impedance_t'(lut[3*{v[43], v[41:40]} +: 3]);
    endfunction : imp_of
    task automatic check(input logic [46:0] v, input int adv);
        `CK(cfg, 1'b1)
        `CK(gain, v[43])
        `CK(fc, v[45:44])
        `CK(imp, imp_of(v))
        `CK(vga, sby & ~pd)
        for (int n = 0; n < 8; n++) begin
            ph = {v[5*n+1], v[5*n+2], v[5*n+3], v[5*n+4]};
            `CK(lop[4*n +: 4], 4'(ph + adv))
            `CK(men[n], ~v[5*n] & ~pd & ~sby)
        end
    endtask : check
    initial begin
        void'($urandom(32'hF4D2));
        repeat (4) @(posedge clk);
        #1 srst = 0;
        `CK({cfg, vga, men}, 10'h000)
        prev = '0;
        for (int i = 0; i < 10; i++) begin
            w = 47'({$urandom, $urandom});
            {w[45:44], w[43], w[42], w[41:40]} = {i[1:0], i[2], i[2:0] == 3'h7, i[1:0]};
            if (i == 8) w = 47'h7BFF_FFFF_FFFF;
            if (i == 9) w = '0;
            {pd, sby} = 2'($urandom_range(3));
            H.send(w, i[0] ? 6 : 3, got);
            `CK(got, prev)
            prev = w;
            repeat (12) @(posedge clk);
            #1 check(w, 0);
            H.run(i + 1);
            repeat (12) @(posedge clk);
            #1 check(w, i + 1);
        end
        srst = 1;
        repeat (4) @(posedge clk);
        #1 srst = 0;
        `CK({cfg, vga, men, imp}, {10'h000, fe_prog_pkg::IMP_100})
        H.send(w, 3, got);
        `CK(got, 47'h0)
        repeat (12) @(posedge clk);
        #1 check(w, 0);
        conclude();
    end
endmodule : beamformer_program_shift_word_tb
bind frontend_program_word fe_prog_monitor #(.CHANNELS(CHANNELS)) mon (.clk, .srst, .ser_clk,
    .chip_select_n, .ser_data_out, .mixer_reference_clock, .power_down_line, .standby_select,
    .configured, .input_impedance_select, .lna_gain_select, .filter_corner_select, .vga_enable,
    .mixer_enable, .lo_phase);
`default_nettype wire
